// ==== dsr_top.sv ====
// Debug serial port command decoder with control and debug registers
// Behaviour
// - Resume command answers 0xFFFF next shift
// - Null command changes nothing, answers 0xFFFF
// - Control register accesses always move 32 bits
// - Read control: three words, address selects register
// - Select is low 12 bits, upper nibble zero
// - Select codes map the core control registers
// - Codes 0x804-0x80B reach the multiply unit
// - Control read returns longword, high word first
// - Two stack pointers, supervisor bit picks roles
// - Accumulator write also changes its extension
// - Write control: opcode word, replaces 32 bits
// - Write answers 0xFFFF, bus error 0x0001 status
// - Debug select five bits, only zero valid
// - Status read clears fault, trigger, halt, breakpoint
// - Status read clears state only when done
// - Debug read returns longword, high word first
// - Debug write replaces 32 bits, answers 0xFFFF
// - Write bus error answers 0x0001 with status; debug write here never bus errors, always answers 0xFFFF
`timescale 1ns/1ps
`default_nettype none

module dsr_top (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic DEBUG_SERIAL_CLOCK,
	input wire logic DSI,
	input wire logic CPU_HALTED,
	input wire logic FAULT_EVT,
	input wire logic TRIG_EVT,
	input wire logic HALT_EVT,
	input wire logic BREAK_EVT,
	input wire logic BREAK_STATE_UPD,
	input wire logic [3:0] BREAK_STATE_VAL,
	input wire logic LVL2_EN,
	output logic DSO,
	output logic RESUME
);
	// ------------------------------------------------------------
	// Link sampling
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_CMD, ST_RC_SH, ST_RC_SL, ST_RD_LO, ST_WC_SH, ST_WC_SL,
		ST_WC_DH, ST_WC_DL, ST_WD_DH, ST_WD_DL
	} dsr_state_type;

	dsr_state_type state_r;
	logic ser_clk_s, dsi_s, ser_clk_d_r, rise;
	logic done, load_r, resume_r, bad_r, dout;
	logic [16:0] rx_word, load_val_r;
	logic [15:0] cmd, data_hi_r, rd_lo_r;
	logic [11:0] sel_r, lk_sel;
	logic [5:0] lk_slot;
	logic [4:0] lk_idx;
	logic sel_ok, rdm_csr, rd_clr, csr_wr, wc_fire, events;
	logic [31:0] creg_r [0:dsr_pkg::NREG-1];
	logic [31:0] act_sp_r, csr_r, wdata;
	logic [3:0] brk_state;

	dsr_sync u_sync_clk (.CLK(CLK), .RESET_N(RESET_N),
		.d_in(DEBUG_SERIAL_CLOCK), .q_out(ser_clk_s));
	dsr_sync u_sync_dat (.CLK(CLK), .RESET_N(RESET_N), .d_in(DSI),
		.q_out(dsi_s));

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ser_clk_d_r <= 1'b0;
		end else if (CE) begin
			ser_clk_d_r <= ser_clk_s;
		end
	end
	assign rise = ser_clk_s & ~ser_clk_d_r;

	dsr_shift u_shift (.CLK(CLK), .RESET_N(RESET_N), .ce(CE), .shift(rise),
		.din(dsi_s), .load(load_r), .load_val(load_val_r), .dout(dout),
		.word(rx_word), .done(done));

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	assign cmd = rx_word[15:0];
	assign lk_sel = (state_r == ST_RC_SL) ? cmd[11:0] : sel_r;
	assign lk_slot = dsr_pkg::sel_slot(lk_sel);
	assign lk_idx = lk_slot[4:0];
	// Select must fit 12 bits with the upper word and nibble clear
	assign sel_ok = lk_slot[5] && !bad_r &&
		(state_r != ST_RC_SL || cmd[15:12] == 4'h0);
	assign rdm_csr = cmd[4:0] == dsr_pkg::DBG_SEL_CSR;
	assign rd_clr = done && state_r == ST_CMD &&
		cmd[15:5] == dsr_pkg::OP_RDM && rdm_csr;
	assign csr_wr = done && state_r == ST_WD_DL;
	assign wc_fire = done && state_r == ST_WC_DL && sel_ok;
	assign wdata = {data_hi_r, cmd};
	assign events = FAULT_EVT | TRIG_EVT | HALT_EVT | BREAK_EVT |
		BREAK_STATE_UPD;
	assign brk_state = csr_r[dsr_pkg::CSR_STATE_LSB +: 4];

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state_r <= ST_CMD;
			load_r <= 1'b0;
			load_val_r <= dsr_pkg::RSP_BUSY;
			resume_r <= 1'b0;
			bad_r <= 1'b0;
			sel_r <= 12'h000;
			data_hi_r <= 16'h0000;
			rd_lo_r <= 16'h0000;
		end else if (CE) begin
			load_r <= 1'b0;
			resume_r <= 1'b0;
			if (done) begin
				load_r <= 1'b1;
				load_val_r <= dsr_pkg::RSP_BUSY;
				unique case (state_r)
					ST_CMD: begin
						if (cmd == dsr_pkg::OP_NOP) begin
							load_val_r <= dsr_pkg::RSP_DONE;
						end else if (cmd == dsr_pkg::OP_GO) begin
							// Resume is ignored while the core runs
							resume_r <= CPU_HALTED;
							load_val_r <= dsr_pkg::RSP_DONE;
						end else if (cmd == dsr_pkg::OP_RCREG) begin
							state_r <= ST_RC_SH;
						end else if (cmd == dsr_pkg::OP_WCREG) begin
							state_r <= ST_WC_SH;
						end else if (cmd[15:5] == dsr_pkg::OP_RDM &&
							rdm_csr) begin
							load_val_r <= {1'b0, csr_r[31:16]};
							rd_lo_r <= csr_r[15:0];
							state_r <= ST_RD_LO;
						end else if (cmd[15:5] == dsr_pkg::OP_WDM &&
							rdm_csr) begin
							state_r <= ST_WD_DH;
						end else begin
							load_val_r <= dsr_pkg::RSP_ILL;
						end
					end
					ST_RC_SH: begin
						bad_r <= cmd != 16'h0000;
						state_r <= ST_RC_SL;
					end
					ST_RC_SL: begin
						if (sel_ok) begin
							load_val_r <= {1'b0, creg_r[lk_idx][31:16]};
							rd_lo_r <= creg_r[lk_idx][15:0];
							state_r <= ST_RD_LO;
						end else begin
							load_val_r <= dsr_pkg::RSP_BERR;
							state_r <= ST_CMD;
						end
					end
					ST_RD_LO: begin
						// The word shifted in here is padding and is dropped
						load_val_r <= {1'b0, rd_lo_r};
						state_r <= ST_CMD;
					end
					ST_WC_SH: begin
						bad_r <= cmd != 16'h0000;
						state_r <= ST_WC_SL;
					end
					ST_WC_SL: begin
						sel_r <= cmd[11:0];
						bad_r <= bad_r | (cmd[15:12] != 4'h0);
						state_r <= ST_WC_DH;
					end
					ST_WC_DH: begin
						data_hi_r <= cmd;
						state_r <= ST_WC_DL;
					end
					ST_WC_DL: begin
						load_val_r <= sel_ok ? dsr_pkg::RSP_DONE
							: dsr_pkg::RSP_BERR;
						state_r <= ST_CMD;
					end
					ST_WD_DH: begin
						data_hi_r <= cmd;
						state_r <= ST_WD_DL;
					end
					ST_WD_DL: begin
						load_val_r <= dsr_pkg::RSP_DONE;
						state_r <= ST_CMD;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Core control registers
	// ------------------------------------------------------------
	// Stack pointers physically swap on a supervisor bit change so the
	// inactive slot always holds the pointer of the other mode.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < dsr_pkg::NREG; i++) begin
				creg_r[i] <= 32'h0000_0000;
			end
			act_sp_r <= 32'h0000_0000;
		end else if (CE && wc_fire) begin
			creg_r[lk_idx] <= wdata;
			if (lk_idx == dsr_pkg::IX_STAT &&
				wdata[dsr_pkg::STAT_SUPER_BIT] !=
				creg_r[dsr_pkg::IX_STAT][dsr_pkg::STAT_SUPER_BIT]) begin
				act_sp_r <= creg_r[dsr_pkg::IX_OSP];
				creg_r[dsr_pkg::IX_OSP] <= act_sp_r;
			end
			// Accumulator load sign-fills its extension half
			unique case (lk_idx)
				dsr_pkg::IX_ACC0:
					creg_r[dsr_pkg::IX_EXT01][15:0] <= {16{wdata[31]}};
				dsr_pkg::IX_ACC1:
					creg_r[dsr_pkg::IX_EXT01][31:16] <= {16{wdata[31]}};
				dsr_pkg::IX_ACC2:
					creg_r[dsr_pkg::IX_EXT23][15:0] <= {16{wdata[31]}};
				dsr_pkg::IX_ACC3:
					creg_r[dsr_pkg::IX_EXT23][31:16] <= {16{wdata[31]}};
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Configuration/status register
	// ------------------------------------------------------------
	// Events are applied last so a set in the clearing cycle survives.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			csr_r <= dsr_pkg::CSR_RESET;
		end else if (CE) begin
			if (csr_wr) begin
				csr_r <= wdata;
			end else if (rd_clr) begin
				csr_r[dsr_pkg::CSR_FAULT] <= 1'b0;
				csr_r[dsr_pkg::CSR_TRIG] <= 1'b0;
				csr_r[dsr_pkg::CSR_HALT] <= 1'b0;
				csr_r[dsr_pkg::CSR_BREAK] <= 1'b0;
				if (brk_state == dsr_pkg::BST_L2_HIT ||
					(brk_state == dsr_pkg::BST_L1_HIT && !LVL2_EN)) begin
					csr_r[dsr_pkg::CSR_STATE_LSB +: 4] <= dsr_pkg::BST_CLEAR;
				end
			end
			if (FAULT_EVT) csr_r[dsr_pkg::CSR_FAULT] <= 1'b1;
			if (TRIG_EVT) csr_r[dsr_pkg::CSR_TRIG] <= 1'b1;
			if (HALT_EVT) csr_r[dsr_pkg::CSR_HALT] <= 1'b1;
			if (BREAK_EVT) csr_r[dsr_pkg::CSR_BREAK] <= 1'b1;
			if (BREAK_STATE_UPD) begin
				csr_r[dsr_pkg::CSR_STATE_LSB +: 4] <= BREAK_STATE_VAL;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			DSO <= 1'b0;
			RESUME <= 1'b0;
		end else if (CE) begin
			DSO <= dout;
			RESUME <= resume_r;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N || !CE);

	nop_answer_a: assert property (done && state_r == ST_CMD &&
		cmd == dsr_pkg::OP_NOP |=> load_r && load_val_r == dsr_pkg::RSP_DONE
		&& state_r == ST_CMD) else $error("null command answer wrong");
	go_answer_a: assert property (done && state_r == ST_CMD &&
		cmd == dsr_pkg::OP_GO && CPU_HALTED |=> load_val_r ==
		dsr_pkg::RSP_DONE ##0 resume_r ##1 RESUME)
		else $error("resume answer or pulse wrong");
	crd_order_a: assert property (done && state_r == ST_RC_SL &&
		sel_ok |=> state_r == ST_RD_LO && load_val_r[16] == 1'b0)
		else $error("control read not returning high word");
	rd_low_a: assert property (done && state_r == ST_RD_LO |=>
		load_val_r == {1'b0, $past(rd_lo_r)} && state_r == ST_CMD)
		else $error("low result word wrong");
	wc_done_a: assert property (wc_fire |=>
		load_val_r == dsr_pkg::RSP_DONE && creg_r[$past(lk_idx)][15:0]
		== $past(cmd)) else $error("control write not completed");
	wc_berr_a: assert property (done && state_r == ST_WC_DL &&
		!sel_ok |=> load_val_r == dsr_pkg::RSP_BERR)
		else $error("bus error answer wrong");
	pc_full_a: assert property (wc_fire && lk_idx == dsr_pkg::IX_PC |=>
		creg_r[dsr_pkg::IX_PC] == $past(wdata))
		else $error("control write not full width");
	acc_ext_a: assert property (wc_fire && lk_idx == dsr_pkg::IX_ACC0 |=>
		creg_r[dsr_pkg::IX_EXT01][15:0] == {16{$past(data_hi_r[15])}})
		else $error("accumulator extension not updated");
	csr_clear_a: assert property (rd_clr && !events |=>
		csr_r[27:24] == 4'h0) else $error("status read did not clear flags");
	rdm_ill_a: assert property (done && state_r == ST_CMD &&
		cmd[15:5] == dsr_pkg::OP_RDM && !rdm_csr && !events |=>
		load_val_r == dsr_pkg::RSP_ILL && $stable(csr_r))
		else $error("reserved debug select not refused");

	rc_seen_c: cover property (done && state_r == ST_RD_LO);
	wc_seen_c: cover property (wc_fire);
	wd_seen_c: cover property (csr_wr);
endmodule : dsr_top

`default_nettype wire

// ==== dsr_pkg.sv ====
// Constants shared by the debug serial command decoder
package dsr_pkg;

	// ------------------------------------------------------------
	// Serial frame and command words
	// ------------------------------------------------------------
	localparam logic [4:0] FRAME_LAST = 5'h10;
	localparam logic [15:0] OP_NOP = 16'h0000;
	localparam logic [15:0] OP_GO = 16'h0c00;
	localparam logic [15:0] OP_RCREG = 16'h2980;
	localparam logic [15:0] OP_WCREG = 16'h2880;
	localparam logic [10:0] OP_RDM = 11'h16c;
	localparam logic [10:0] OP_WDM = 11'h164;
	localparam logic [4:0] DBG_SEL_CSR = 5'h00;

	// ------------------------------------------------------------
	// Responses: status bit on top of a 16-bit word
	// ------------------------------------------------------------
	localparam logic [16:0] RSP_DONE = 17'h0ffff;
	localparam logic [16:0] RSP_BERR = 17'h10001;
	localparam logic [16:0] RSP_ILL = 17'h1ffff;
	localparam logic [16:0] RSP_BUSY = 17'h00000;

	// ------------------------------------------------------------
	// Configuration/status register layout
	// ------------------------------------------------------------
	localparam logic [31:0] CSR_RESET = 32'h0000_0000;
	localparam int CSR_STATE_LSB = 28;
	localparam int CSR_FAULT = 27;
	localparam int CSR_TRIG = 26;
	localparam int CSR_HALT = 25;
	localparam int CSR_BREAK = 24;
	localparam logic [3:0] BST_L1_HIT = 4'h2;
	localparam logic [3:0] BST_L2_HIT = 4'h6;
	localparam logic [3:0] BST_CLEAR = 4'h0;

	// ------------------------------------------------------------
	// Control register select codes and storage slots
	// ------------------------------------------------------------
	localparam int NREG = 17;
	localparam int STAT_SUPER_BIT = 13;
	localparam logic [4:0] IX_OSP = 5'h03;
	localparam logic [4:0] IX_ACC0 = 5'h07;
	localparam logic [4:0] IX_EXT01 = 5'h08;
	localparam logic [4:0] IX_EXT23 = 5'h09;
	localparam logic [4:0] IX_ACC1 = 5'h0a;
	localparam logic [4:0] IX_ACC2 = 5'h0b;
	localparam logic [4:0] IX_ACC3 = 5'h0c;
	localparam logic [4:0] IX_STAT = 5'h0d;
	localparam logic [4:0] IX_PC = 5'h0e;

	// Maps a 12-bit select code to a storage slot; hit low if unmapped
	function automatic logic [5:0] sel_slot(input logic [11:0] sel);
		unique case (sel)
			12'h002: sel_slot = 6'h20;
			12'h004: sel_slot = 6'h21;
			12'h005: sel_slot = 6'h22;
			12'h800: sel_slot = 6'h23;
			12'h801: sel_slot = 6'h24;
			12'h804: sel_slot = 6'h25;
			12'h805: sel_slot = 6'h26;
			12'h806: sel_slot = 6'h27;
			12'h807: sel_slot = 6'h28;
			12'h808: sel_slot = 6'h29;
			12'h809: sel_slot = 6'h2a;
			12'h80a: sel_slot = 6'h2b;
			12'h80b: sel_slot = 6'h2c;
			12'h80e: sel_slot = 6'h2d;
			12'h80f: sel_slot = 6'h2e;
			12'hc04: sel_slot = 6'h2f;
			12'hc05: sel_slot = 6'h30;
			default: sel_slot = 6'h00;
		endcase
	endfunction : sel_slot

endpackage : dsr_pkg

// ==== dsr_sync.sv ====
// Two-flop synchroniser for one asynchronous input
`timescale 1ns/1ps
`default_nettype none

module dsr_sync (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic d_in,
	output logic q_out
);
	logic meta_r;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			meta_r <= 1'b0;
			q_out <= 1'b0;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule : dsr_sync

`default_nettype wire

// ==== dsr_shift.sv ====
// 17-bit serial receive and transmit shifter with frame counter
`timescale 1ns/1ps
`default_nettype none

module dsr_shift (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic ce,
	input wire logic shift,
	input wire logic din,
	input wire logic load,
	input wire logic [16:0] load_val,
	output logic dout,
	output logic [16:0] word,
	output logic done
);
	logic [16:0] tx_r;
	logic [4:0] cnt_r;

	assign dout = tx_r[16];

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			word <= 17'h00000;
			tx_r <= dsr_pkg::RSP_BUSY;
			cnt_r <= 5'h00;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (load) begin
				tx_r <= load_val;
			end else if (shift) begin
				tx_r <= {tx_r[15:0], 1'b0};
			end
			if (shift) begin
				word <= {word[15:0], din};
				if (cnt_r == dsr_pkg::FRAME_LAST) begin
					cnt_r <= 5'h00;
					done <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 5'h01;
				end
			end
		end
	end
endmodule : dsr_shift

`default_nettype wire

// ==== dsr_host.sv ====
// Serial development-host model driving the debug link
`timescale 1ns/1ps
`default_nettype none

module dsr_host (
	output logic DEBUG_SERIAL_CLOCK,
	output logic DSI,
	input wire logic DSO
);
	// Clock rests low between frames
	initial begin
		DEBUG_SERIAL_CLOCK = 1'b0;
		DSI = 1'b0;
	end

	// ------------------------------------------------------------
	// One 17-bit frame, MSB first
	// ------------------------------------------------------------
	task automatic frame(input logic [16:0] tx, output logic [16:0] rx);
		for (int i = 16; i >= 0; i--) begin
			DSI = tx[i];
			#80;
			// Sampled just before the rise, when the bit has settled
			rx[i] = DSO;
			DEBUG_SERIAL_CLOCK = 1'b1;
			#80;
			DEBUG_SERIAL_CLOCK = 1'b0;
		end
		// Idle data must not keep showing the last bit; the gap keeps this
		// change apart from the next frame's first bit
		DSI = ~tx[0];
		#40;
	endtask : frame
endmodule : dsr_host
`default_nettype wire

// ==== dsr_top_tb_top.sv ====
// Self-checking testbench for the debug serial command decoder
`timescale 1ns/1ps
`default_nettype none

module dsr_top_tb_top;
	typedef struct {logic [15:0] sel; logic [31:0] dat;} dsr_row_type;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic CE = 1'b1;
	logic CPU_HALTED = 1'b0;
	logic [3:0] evt = 4'h0;
	logic BREAK_STATE_UPD = 1'b0;
	logic [3:0] BREAK_STATE_VAL = 4'h0;
	logic LVL2_EN = 1'b0;
	logic DEBUG_SERIAL_CLOCK;
	logic DSI;
	logic DSO;
	logic RESUME;
	int failures = 0;
	int compares = 0;
	int resumes = 0;
	int n;
	dsr_row_type rows [8] = '{'{16'h0002, 32'h1234_5678},
		'{16'h0004, 32'h89ab_cdef}, '{16'h0005, 32'hffff_0000},
		'{16'h0801, 32'h0000_ffff}, '{16'h080f, 32'ha5a5_5a5a},
		'{16'h0c04, 32'h0123_4567}, '{16'h0c05, 32'hfedc_ba98},
		'{16'h0805, 32'h00ff_ff00}};

	dsr_top i_dsr_top (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.CE(CE),
		.DEBUG_SERIAL_CLOCK(DEBUG_SERIAL_CLOCK),
		.DSI(DSI),
		.CPU_HALTED(CPU_HALTED),
		.FAULT_EVT(evt[3]),
		.TRIG_EVT(evt[2]),
		.HALT_EVT(evt[1]),
		.BREAK_EVT(evt[0]),
		.BREAK_STATE_UPD(BREAK_STATE_UPD),
		.BREAK_STATE_VAL(BREAK_STATE_VAL),
		.LVL2_EN(LVL2_EN),
		.DSO(DSO),
		.RESUME(RESUME)
	);

	dsr_host i_dsr_host (
		.DEBUG_SERIAL_CLOCK(DEBUG_SERIAL_CLOCK),
		.DSI(DSI),
		.DSO(DSO)
	);

	always #5 CLK = ~CLK;

	always @(posedge CLK) begin
		if (RESUME === 1'b1) begin
			resumes++;
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic xf(input logic [15:0] w, input logic [16:0] e,
		input bit c);
		logic [16:0] r;
		i_dsr_host.frame({1'b0, w}, r);
		if (c) begin
			chk("DSO frame", {15'h0, e}, {15'h0, r});
		end
	endtask : xf

	// Select longword then data longword, high words first
	task automatic wcr(input logic [15:0] s, input logic [31:0] d,
		input logic [16:0] e);
		xf(dsr_pkg::OP_WCREG, dsr_pkg::RSP_BUSY, 0);
		xf(16'h0000, dsr_pkg::RSP_BUSY, 1);
		xf(s, dsr_pkg::RSP_BUSY, 1);
		xf(d[31:16], dsr_pkg::RSP_BUSY, 1);
		xf(d[15:0], dsr_pkg::RSP_BUSY, 1);
		xf(dsr_pkg::OP_NOP, e, 1);
	endtask : wcr

	task automatic rcr(input logic [15:0] s, input logic [31:0] d);
		xf(dsr_pkg::OP_RCREG, dsr_pkg::RSP_BUSY, 0);
		xf(16'h0000, dsr_pkg::RSP_BUSY, 1);
		xf(s, dsr_pkg::RSP_BUSY, 1);
		xf(dsr_pkg::OP_NOP, {1'b0, d[31:16]}, 1);
		xf(dsr_pkg::OP_NOP, {1'b0, d[15:0]}, 1);
	endtask : rcr

	task automatic rdm(input logic [31:0] d);
		xf({dsr_pkg::OP_RDM, dsr_pkg::DBG_SEL_CSR}, 17'h0, 0);
		xf(dsr_pkg::OP_NOP, {1'b0, d[31:16]}, 1);
		xf(dsr_pkg::OP_NOP, {1'b0, d[15:0]}, 1);
	endtask : rdm

	task automatic wdm(input logic [31:0] d);
		xf({dsr_pkg::OP_WDM, dsr_pkg::DBG_SEL_CSR}, 17'h0, 0);
		xf(d[31:16], dsr_pkg::RSP_BUSY, 1);
		xf(d[15:0], dsr_pkg::RSP_BUSY, 1);
		xf(dsr_pkg::OP_NOP, dsr_pkg::RSP_DONE, 1);
	endtask : wdm

	task automatic ev(input logic [3:0] f, input logic [3:0] b);
		@(negedge CLK);
		evt = f;
		BREAK_STATE_VAL = b;
		BREAK_STATE_UPD = 1'b1;
		@(negedge CLK);
		evt = 4'h0;
		BREAK_STATE_UPD = 1'b0;
	endtask : ev

	// Two edges; the synchronisers clear on the first one
	task automatic do_reset();
		@(negedge CLK);
		RESET_N = 1'b0;
		repeat (2) @(negedge CLK);
		chk("DSO in reset", 32'h0, {31'h0, DSO});
		chk("RESUME in reset", 32'h0, {31'h0, RESUME});
		RESET_N = 1'b1;
		repeat (4) @(negedge CLK);
	endtask : do_reset

	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask : tdone

	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Roughly 240 frames of 2.76 us each, plus a third to spare
	initial begin
		#900_000;
		failures++;
		$display("BAD watchdog expected finish seen timeout");
		give_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		xf(dsr_pkg::OP_NOP, 17'h0, 0);
		xf(dsr_pkg::OP_NOP, dsr_pkg::RSP_DONE, 1);
		tdone("null");
		@(negedge CLK);
		CPU_HALTED = 1'b1;
		n = resumes;
		xf(dsr_pkg::OP_GO, 17'h0, 0);
		xf(dsr_pkg::OP_NOP, dsr_pkg::RSP_DONE, 1);
		chk("resume pulses", n + 1, resumes);
		@(negedge CLK);
		CPU_HALTED = 1'b0;
		xf(dsr_pkg::OP_GO, 17'h0, 0);
		xf(dsr_pkg::OP_NOP, dsr_pkg::RSP_DONE, 1);
		chk("resume ignored", n + 1, resumes);
		tdone("resume");
		foreach (rows[i]) begin
			wcr(rows[i].sel, rows[i].dat, dsr_pkg::RSP_DONE);
			rcr(rows[i].sel, rows[i].dat);
		end
		tdone("control table");
		wcr(16'h0003, 32'hdead_beef, dsr_pkg::RSP_BERR);
		wcr(16'h1002, 32'hdead_beef, dsr_pkg::RSP_BERR);
		rcr(16'h0002, 32'h1234_5678);
		xf(16'h7777, 17'h0, 0);
		xf(dsr_pkg::OP_NOP, dsr_pkg::RSP_ILL, 1);
		tdone("refusals");
		wcr(16'h0800, 32'h0000_1000, dsr_pkg::RSP_DONE);
		wcr(16'h080e, 32'h0000_2000, dsr_pkg::RSP_DONE);
		rcr(16'h080e, 32'h0000_2000);
		rcr(16'h0800, 32'h0000_0000);
		wcr(16'h080e, 32'h0000_0000, dsr_pkg::RSP_DONE);
		rcr(16'h0800, 32'h0000_1000);
		tdone("stack pointers");
		// Rounding off around accumulator traffic
		rcr(16'h0804, 32'h0);
		wcr(16'h0804, 32'h0, dsr_pkg::RSP_DONE);
		wcr(16'h0806, 32'h8000_0001, dsr_pkg::RSP_DONE);
		wcr(16'h080b, 32'h8000_0000, dsr_pkg::RSP_DONE);
		rcr(16'h0806, 32'h8000_0001);
		rcr(16'h0807, 32'h0000_ffff);
		rcr(16'h0808, 32'hffff_0000);
		wcr(16'h0807, 32'h0000_1234, dsr_pkg::RSP_DONE);
		rcr(16'h0807, 32'h0000_1234);
		wcr(16'h0804, 32'h0, dsr_pkg::RSP_DONE);
		tdone("multiply unit");
		rdm(32'h0);
		wdm(32'h00ab_1234);
		rdm(32'h00ab_1234);
		LVL2_EN = 1'b1;
		ev(4'hf, dsr_pkg::BST_L1_HIT);
		xf({dsr_pkg::OP_RDM, 5'h01}, 17'h0, 0);
		xf(dsr_pkg::OP_NOP, dsr_pkg::RSP_ILL, 1);
		rdm(32'h2fab_1234);
		rdm(32'h20ab_1234);
		@(negedge CLK);
		LVL2_EN = 1'b0;
		rdm(32'h20ab_1234);
		rdm(32'h00ab_1234);
		@(negedge CLK);
		LVL2_EN = 1'b1;
		ev(4'h0, dsr_pkg::BST_L2_HIT);
		rdm(32'h60ab_1234);
		rdm(32'h00ab_1234);
		tdone("debug status");
		do_reset();
		rdm(32'h0);
		rcr(16'h0002, 32'h0);
		tdone("second reset");
		give_verdict();
	end
endmodule : dsr_top_tb_top
`default_nettype wire
